//--- src/nvm_security_margin_commands.sv
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - code 0x0B at index 000 erases all, verifies, then releases security.
// - failed erase verify sets any-verify-error, security stays unchanged.
// - host launches by clearing flag; flag sets again when work finishes.
// - unsecure flags access error on index not 000 or mode not allowed.
// - unsecure flags protection violation when any region is protected.
// - verify errors set any-error bit; uncorrectable ones set second bit.
// - key verify runs only when key enable equals 10, else access error.
// - key verify is code 0x0C, keys at 001..100; final index must be 100.
// - four keys compared with stored keys from 0xFF70; match releases.
// - mismatch keeps security, access error, locks key verify until reset.
// - margin is code 0x0D, address at 000/001, level at 010.
// - global address bit 23 selects flash (0) or EEPROM (1) block.
// - margin command stores level for addressed block, then completes.
// - EEPROM margin hits EEPROM reads only; flash margin hits both.
// - level 0 normal, 1 user margin-1 (erased), 2 user margin-0.
// - user margin-0 reads with margin toward the programmed state.
// - margin command access error on index, address or level invalid.
module nvm_security_margin_commands
  import nvm_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output arr_req_type      arr_req,
  input  wire arr_rsp_type arr_rsp,
  input  wire logic        cmd_mode_ok,
  input  wire logic        region_protected,
  input  wire logic        config_secured,
  input  wire logic [1:0]  backdoor_key_enable,
  input  wire key_set_type backdoor_keys,
  output margin_type       read_margin,
  output logic             secured,
  output logic             irq
);

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE       = 3'b000,
    S_FETCH      = 3'b001,
    S_DECODE     = 3'b011,
    S_ERASE      = 3'b010,
    S_KEYCMP     = 3'b110,
    S_MARGIN_SET = 3'b111,
    S_FINISH     = 3'b101
  } state_type;

  state_type state_r;
  state_type state_nxt;

  logic        command_complete_flag;
  logic        access_error_flag;
  logic        protection_violation_flag;
  logic [1:0]  verify_status_bits;
  logic [2:0]  command_word_index;
  logic        lock_r;
  logic        sec_loaded_r;
  logic [1:0]  cnt_r;
  logic        key_bad_r;
  logic        tgt_eeprom_r;
  logic [1:0]  rd_stage_r;
  logic [31:0] readdata_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  margin_type  margin_r;

  logic [31:0] wmask;
  logic [31:0] wd;
  logic [4:0]  reg_off;
  logic        idle;
  logic        launch;
  logic        acc_set;
  logic        fpv_set;
  logic        unsec_ok;
  logic        key_bad_now;
  logic        rd_word;
  logic        rd_go;
  logic [2:0]  mem_raddr;
  logic [15:0] mem_rdata;
  logic [7:0]  cmd_code;
  logic [IRQ_W-1:0] irq_ev;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign reg_off = {address[4:2], 2'b00};
  assign idle    = (state_r == S_IDLE);
  assign cmd_code = mem_rdata[15:8];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{byteenable[i]}};
    end
    wd = writedata & wmask;
  end

  // launch refused while an error flag is still pending
  assign launch = write && (reg_off == OFF_STATUS) && wd[CMPL_BIT]
                  && command_complete_flag && !access_error_flag
                  && !protection_violation_flag;

  // word store is shared with the sequencer, so word reads wait for idle
  assign rd_word = (reg_off == OFF_CMDWORD);
  assign rd_go   = read && !(rd_word && !idle);
  assign waitrequest = read && (rd_stage_r != 2'd2);
  assign readdata    = readdata_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_stage_r <= 2'd0;
    end else if (rd_stage_r == 2'd2) begin
      rd_stage_r <= 2'd0;
    end else if (rd_go) begin
      rd_stage_r <= rd_stage_r + 2'd1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata_r <= 32'h0000_0000;
    end else if (rd_stage_r == 2'd1) begin
      readdata_r <= 32'h0000_0000;
      unique case (reg_off)
        OFF_STATUS: begin
          readdata_r[CMPL_BIT]   <= command_complete_flag;
          readdata_r[AERR_BIT]   <= access_error_flag;
          readdata_r[PVIOL_BIT]  <= protection_violation_flag;
          readdata_r[1:0]        <= verify_status_bits;
        end
        OFF_INDEX:    readdata_r[2:0]  <= command_word_index;
        OFF_CMDWORD:  readdata_r[15:0] <= mem_rdata;
        OFF_SECURITY: begin
          readdata_r[SEC_BIT]  <= secured;
          readdata_r[LOCK_BIT] <= lock_r;
          readdata_r[1:0]      <= backdoor_key_enable;
        end
        OFF_MARGIN:   readdata_r[3:0] <= margin_r;
        OFF_IRQ_STAT: readdata_r[IRQ_W-1:0] <= irq_stat_r;
        OFF_IRQ_MASK: readdata_r[IRQ_W-1:0] <= irq_mask_r;
        default:      readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command word store
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      command_word_index <= INDEX_RST;
    end else if (write && reg_off == OFF_INDEX && byteenable[0]) begin
      command_word_index <= wd[2:0];
    end
  end

  always_comb begin
    unique case (state_r)
      S_FETCH:  mem_raddr = 3'd0;
      S_DECODE: mem_raddr = (cmd_code == CMD_KEYVERIFY) ? 3'd1 : 3'd2;
      S_KEYCMP: mem_raddr = 3'(cnt_r) + 3'd2;
      default:  mem_raddr = command_word_index;
    endcase
  end

  cmd_word_mem u_words (
    .clk   (clk),
    .rstn  (rstn),
    .we    (write && reg_off == OFF_CMDWORD && idle),
    .be    (byteenable[1:0]),
    .waddr (command_word_index),
    .wdata (wd[15:0]),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign key_bad_now = key_bad_r
                       || (mem_rdata != backdoor_keys[cnt_r]);

  always_comb begin
    state_nxt = state_r;
    acc_set   = 1'b0;
    fpv_set   = 1'b0;
    unsec_ok  = 1'b0;
    unique case (state_r)
      S_IDLE: begin
        if (launch) begin
          state_nxt = S_FETCH;
        end
      end
      S_FETCH: state_nxt = S_DECODE;
      S_DECODE: begin
        state_nxt = S_FINISH;
        unique case (cmd_code)
          CMD_UNSECURE: begin
            if (command_word_index != IDX_UNSECURE || !cmd_mode_ok) begin
              acc_set = 1'b1;
            end else if (region_protected) begin
              fpv_set = 1'b1;
            end else begin
              state_nxt = S_ERASE;
            end
          end
          CMD_KEYVERIFY: begin
            if (command_word_index != IDX_KEYVERIFY || !cmd_mode_ok
                || backdoor_key_enable != KEYS_ON || lock_r) begin
              acc_set = 1'b1;
            end else begin
              state_nxt = S_KEYCMP;
            end
          end
          CMD_MARGIN: begin
            if (command_word_index != IDX_MARGIN || !cmd_mode_ok
                || mem_rdata[BLOCK_SEL_BIT-1:0] != 7'h00) begin
              acc_set = 1'b1;
            end else begin
              state_nxt = S_MARGIN_SET;
            end
          end
          default: acc_set = 1'b1;
        endcase
      end
      S_ERASE: begin
        if (arr_rsp.done) begin
          state_nxt = S_FINISH;
        end
      end
      S_KEYCMP: begin
        if (cnt_r == LAST_KEY) begin
          state_nxt = S_FINISH;
          acc_set   = key_bad_now;
          unsec_ok  = !key_bad_now;
        end
      end
      S_MARGIN_SET: begin
        state_nxt = S_FINISH;
        acc_set   = (mem_rdata > MARGIN_MAX);
      end
      S_FINISH: state_nxt = S_IDLE;
      default:  state_nxt = S_IDLE;
    endcase
    if (state_r == S_ERASE && arr_rsp.done && !arr_rsp.verify_fail) begin
      unsec_ok = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r        <= 2'd0;
      key_bad_r    <= 1'b0;
      tgt_eeprom_r <= 1'b0;
    end else if (state_r == S_DECODE) begin
      cnt_r        <= 2'd0;
      key_bad_r    <= 1'b0;
      tgt_eeprom_r <= mem_rdata[BLOCK_SEL_BIT];
    end else if (state_r == S_KEYCMP) begin
      cnt_r     <= cnt_r + 2'd1;
      key_bad_r <= key_bad_now;
    end
  end

  // erase request held until the array reports the verify result
  assign arr_req.erase_all = (state_r == S_ERASE);

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      command_complete_flag <= CMPL_RST;
    end else if (launch) begin
      command_complete_flag <= 1'b0;
    end else if (state_r == S_FINISH) begin
      command_complete_flag <= 1'b1;
    end
  end

  // set wins over a one-written clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
    end else begin
      access_error_flag <= acc_set || (access_error_flag
        && !(write && reg_off == OFF_STATUS && wd[AERR_BIT]));
      protection_violation_flag <= fpv_set || (protection_violation_flag
        && !(write && reg_off == OFF_STATUS && wd[PVIOL_BIT]));
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      verify_status_bits <= 2'b00;
    end else if (launch) begin
      verify_status_bits <= 2'b00;
    end else if (state_r == S_ERASE && arr_rsp.done) begin
      verify_status_bits[ANYERR_BIT] <= arr_rsp.verify_fail;
      verify_status_bits[UNCORR_BIT] <= arr_rsp.verify_uncorr;
    end
  end

  // ----------------------------------------------------------------
  // security state
  // ----------------------------------------------------------------
  // power-up security level is caught on the first edge after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      secured      <= SECURE_RST;
      sec_loaded_r <= 1'b0;
    end else if (!sec_loaded_r) begin
      secured      <= config_secured;
      sec_loaded_r <= 1'b1;
    end else if (unsec_ok) begin
      secured <= 1'b0;
    end
  end

  // only reset lifts the lockout
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_r <= 1'b0;
    end else if (state_r == S_KEYCMP && cnt_r == LAST_KEY && key_bad_now) begin
      lock_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read margins
  // ----------------------------------------------------------------
  // flash target drives both blocks; no flash-only setting is possible
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      margin_r <= '{flash: MARGIN_NORMAL, eeprom: MARGIN_NORMAL};
    end else if (state_r == S_MARGIN_SET && mem_rdata <= MARGIN_MAX) begin
      margin_r.eeprom <= margin_level_type'(mem_rdata[1:0]);
      if (!tgt_eeprom_r) begin
        margin_r.flash <= margin_level_type'(mem_rdata[1:0]);
      end
    end
  end

  assign read_margin = margin_r;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_ev = {unsec_ok, fpv_set, acc_set, state_r == S_FINISH};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= '0;
    end else if (write && reg_off == OFF_IRQ_STAT) begin
      irq_stat_r <= irq_ev | (irq_stat_r & ~wd[IRQ_W-1:0]);
    end else begin
      irq_stat_r <= irq_ev | irq_stat_r;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else if (write && reg_off == OFF_IRQ_MASK) begin
      irq_mask_r <= (irq_mask_r & ~wmask[IRQ_W-1:0]) | wd[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire

//--- pkg/nvm_seq_pkg.sv
package nvm_seq_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_STATUS   = 5'h00;
  localparam logic [4:0] OFF_INDEX    = 5'h04;
  localparam logic [4:0] OFF_CMDWORD  = 5'h08;
  localparam logic [4:0] OFF_SECURITY = 5'h0C;
  localparam logic [4:0] OFF_MARGIN   = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMPL_BIT    = 7;
  localparam int AERR_BIT    = 5;
  localparam int PVIOL_BIT   = 4;
  localparam int ANYERR_BIT  = 1;
  localparam int UNCORR_BIT  = 0;
  localparam int SEC_BIT     = 7;
  localparam int LOCK_BIT    = 6;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_AERR    = 1;
  localparam int IRQ_PVIOL   = 2;
  localparam int IRQ_UNSEC   = 3;
  localparam int IRQ_W       = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic       CMPL_RST    = 1'b1;
  localparam logic       SECURE_RST  = 1'b1;
  localparam logic [2:0] INDEX_RST   = 3'h0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // command codes, indices, keys, margins
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_UNSECURE  = 8'h0B;
  localparam logic [7:0] CMD_KEYVERIFY = 8'h0C;
  localparam logic [7:0] CMD_MARGIN    = 8'h0D;
  localparam logic [2:0] IDX_UNSECURE  = 3'h0;
  localparam logic [2:0] IDX_KEYVERIFY = 3'h4;
  localparam logic [2:0] IDX_MARGIN    = 3'h2;
  localparam logic [1:0] KEYS_ON       = 2'h2;
  localparam logic [1:0] LAST_KEY      = 2'h3;
  // config-field word holding key 0; keys 1..3 follow it
  localparam logic [15:0] KEY0_CFG_ADDR = 16'hFF70;
  localparam int          BLOCK_SEL_BIT = 7;  // global address [23]
  localparam logic [15:0] MARGIN_MAX    = 16'h0002;

  typedef enum logic [1:0] {
    MARGIN_NORMAL = 2'h0,
    MARGIN_USER1  = 2'h1,  // toward erased state
    MARGIN_USER0  = 2'h2   // toward programmed state
  } margin_level_type;

  typedef struct packed {
    margin_level_type flash;
    margin_level_type eeprom;
  } margin_type;

  typedef struct packed {
    logic erase_all;
  } arr_req_type;

  typedef struct packed {
    logic done;
    logic verify_fail;
    logic verify_uncorr;
  } arr_rsp_type;

  typedef logic [3:0][15:0] key_set_type;

endpackage

//--- src/cmd_word_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_word_mem (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        we,
  input  wire logic [1:0]  be,
  input  wire logic [2:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic [2:0]  raddr,
  output logic      [15:0] rdata
);

  logic [15:0] mem [0:7];

  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (we && be[i]) begin
        mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

//--- sim/nvm_array_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_array_model
  import nvm_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire arr_req_type arr_req,
  output arr_rsp_type      arr_rsp,
  input  wire logic        fail_i,
  input  wire logic        uncorr_i,
  input  wire logic [7:0]  dly
);
  logic [8:0] cnt_r;
  logic       done_r;
  logic       tog_r;
  // ------------------------------------------------------------
  // erase and verify, one done pulse per request
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      done_r <= 1'b0;
      tog_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      done_r <= arr_req.erase_all && (cnt_r == {1'b0, dly});
      if (!arr_req.erase_all) begin
        cnt_r <= '0;
      end else if (cnt_r <= {1'b0, dly}) begin
        cnt_r <= cnt_r + 9'h001;
      end
    end
  end
  // verify bits mean nothing outside done, so they toggle there
  assign arr_rsp.done = done_r;
  assign arr_rsp.verify_fail = done_r ? fail_i : tog_r;
  assign arr_rsp.verify_uncorr = done_r ? uncorr_i : ~tog_r;
endmodule
`default_nettype wire

//--- sim/nvm_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_seq_chk
  import nvm_seq_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  input wire arr_req_type arr_req,
  input wire arr_rsp_type arr_rsp,
  input wire logic        cmd_mode_ok,
  input wire logic        region_protected,
  input wire margin_type  read_margin,
  input wire logic        secured
);
  logic [2:0] go_r;
  logic       ers;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  assign ers = arr_req.erase_all;
  // ------------------------------------------------------------
  // recent allowed launches, so erase can be tied to its cause
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      go_r <= '0;
    end else begin
      go_r <= {go_r[1:0], write && address[4:2] == OFF_STATUS[4:2]
               && writedata[CMPL_BIT] && cmd_mode_ok && !region_protected};
    end
  end
  sequence rd_answer;
    waitrequest ##1 (read && waitrequest) ##1 !waitrequest;
  endsequence
  AST_ERASE_HOLD: assert property (ers && !arr_rsp.done |=> ers)
    else $error("erase request dropped before done");
  AST_ERASE_END: assert property (ers && arr_rsp.done |=> !ers)
    else $error("erase request held after done");
  AST_UNSEC_OK: assert property (ers && arr_rsp.done
    && !arr_rsp.verify_fail |=> !secured)
    else $error("security kept after good erase verify");
  AST_UNSEC_FAIL: assert property (ers && arr_rsp.done
    && arr_rsp.verify_fail |=> $stable(secured))
    else $error("security changed after failed verify");
  AST_ERASE_CAUSE: assert property ($rose(ers) |-> |go_r)
    else $error("erase started without allowed launch");
  AST_SEC_NO_RISE: assert property (!$rose(secured))
    else $error("security set again without reset");
  AST_WR_NOWAIT: assert property (write |-> !waitrequest)
    else $error("write stalled");
  AST_RD_ANSWER: assert property ($rose(read)
    && address[4:2] != OFF_CMDWORD[4:2] |-> rd_answer)
    else $error("read answer timing wrong");
  AST_MARGIN_BOTH: assert property ($changed(read_margin.flash)
    |-> read_margin.eeprom == read_margin.flash)
    else $error("flash margin not applied to eeprom");
  AST_MARGIN_CODE: assert property (read_margin.flash != 2'h3
    && read_margin.eeprom != 2'h3)
    else $error("undefined margin level stored");
endmodule
bind nvm_security_margin_commands nvm_seq_chk u_chk (
  .clk(clk), .rstn(rstn), .address(address), .read(read),
  .write(write), .writedata(writedata), .waitrequest(waitrequest),
  .arr_req(arr_req), .arr_rsp(arr_rsp), .cmd_mode_ok(cmd_mode_ok),
  .region_protected(region_protected), .read_margin(read_margin),
  .secured(secured));
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import nvm_seq_pkg::*;
;
  logic        clk, rstn, read, write, waitrequest, secured, irq;
  logic        cmd_mode_ok, region_protected, config_secured;
  logic        fail_i, uncorr_i, busy_q;
  logic [4:0]  address;
  logic [3:0]  byteenable, cur;
  logic [7:0]  dly;
  logic [31:0] writedata, readdata, rd_q, seed;
  logic [15:0] lvl;
  logic [1:0]  backdoor_key_enable;
  logic [15:0] cw [5];
  key_set_type backdoor_keys;
  arr_req_type arr_req;
  arr_rsp_type arr_rsp;
  margin_type  read_margin;
  int          error_cnt, compares;
  nvm_security_margin_commands u_nvm_security_margin_commands (
    .clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .arr_req(arr_req),
    .arr_rsp(arr_rsp), .cmd_mode_ok(cmd_mode_ok),
    .region_protected(region_protected), .config_secured(config_secured),
    .backdoor_key_enable(backdoor_key_enable),
    .backdoor_keys(backdoor_keys), .read_margin(read_margin),
    .secured(secured), .irq(irq));
  nvm_array_model u_nvm_array_model (.clk(clk), .rstn(rstn),
    .arr_req(arr_req), .arr_rsp(arr_rsp), .fail_i(fail_i),
    .uncorr_i(uncorr_i), .dly(dly));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // flash-block margin lands on both blocks, bad levels store nothing
  function automatic logic [3:0] exp_mg(input logic [3:0] c,
      input logic blk, input logic [15:0] l);
    if (l > MARGIN_MAX) return c;
    if (blk) return {c[3:2], l[1:0]};
    return {l[1:0], l[1:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // bus master: hold until waitrequest low, then release
  // ------------------------------------------------------------
  task automatic bus(input logic rd, input logic [4:0] a,
      input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest && n < 100);
    if (n >= 100) error_cnt++;
    rd_q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rst;
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic clr;
    bus(0, OFF_STATUS, 32'h0000_0030, 4'h1);
    bus(0, OFF_IRQ_STAT, 32'h0000_000F, 4'h1);
  endtask
  // load n words, set final index, launch, poll for completion
  task automatic run(input int n, input logic [2:0] idx);
    int k;
    k = 0;
    for (int i = 0; i < n; i++) begin
      bus(0, OFF_INDEX, 32'(i), 4'h1);
      bus(0, OFF_CMDWORD, {16'h0000, cw[i]}, 4'h3);
    end
    bus(0, OFF_INDEX, {29'h0, idx}, 4'h1);
    bus(0, OFF_STATUS, 32'h0000_0080, 4'h1);
    bus(1, OFF_STATUS, 32'h0, 4'h0);
    busy_q = rd_q[CMPL_BIT];
    // only status polls while busy
    while (!rd_q[CMPL_BIT] && k < 200) begin
      bus(1, OFF_STATUS, 32'h0, 4'h0);
      k++;
    end
    if (k >= 200) error_cnt++;
  endtask
  initial begin
    #400_000;
    error_cnt++;
    results();
  end
  initial begin
    {read, write, address, writedata, byteenable} = '0;
    {fail_i, uncorr_i, region_protected} = '0;
    {cmd_mode_ok, config_secured, dly} = {2'b11, 8'd2};
    backdoor_key_enable = 2'b10;
    seed = 32'hc2f8;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      backdoor_keys[i] = seed[15:0];
    end
    rst();
    bus(1, OFF_STATUS, 32'h0, 4'h0);
    chk(rd_q, 32'h0000_0080);
    bus(1, 5'h1C, 32'h0, 4'h0);
    chk(rd_q, 32'h0);
    chk(secured, 1'b1);
    bus(0, OFF_INDEX, 32'h0000_0003, 4'h1);
    bus(0, OFF_CMDWORD, 32'h0000_5AA5, 4'h3);
    bus(1, OFF_INDEX, 32'h0, 4'h0);
    chk(rd_q, 32'h0000_0003);
    bus(1, OFF_CMDWORD, 32'h0, 4'h0);
    chk(rd_q, 32'h0000_5AA5);
    cw[0] = {CMD_UNSECURE, 8'h00};
    for (int m = 0; m < 3; m++) begin
      cmd_mode_ok <= (m != 1);
      region_protected <= (m == 2);
      run(1, (m == 0) ? 3'h1 : 3'h0);
      chk(rd_q[AERR_BIT], m < 2);
      chk(rd_q[PVIOL_BIT], m == 2);
      chk(irq, 1'b0);
      clr();
    end
    {cmd_mode_ok, region_protected} <= 2'b10;
    bus(0, OFF_IRQ_MASK, 32'h0000_0008, 4'h1);
    for (int m = 0; m < 3; m++) begin
      fail_i <= (m < 2);
      uncorr_i <= (m == 0);
      dly <= (m == 0) ? 8'd150 : 8'd0;
      run(1, 3'h0);
      chk(busy_q, 1'b0);
      chk(rd_q[1:0], {m < 2, m == 0});
      chk(secured, m < 2);
      chk(irq, m == 2);
    end
    clr();
    bus(1, OFF_IRQ_STAT, 32'h0, 4'h0);
    chk(rd_q, 32'h0);
    chk(irq, 1'b0);
    rst();
    // host code here stands for code run from ram
    cw[0] = {CMD_KEYVERIFY, 8'h00};
    for (int i = 0; i < 4; i++) cw[i+1] = backdoor_keys[i];
    for (int e = 0; e < 4; e++) begin
      backdoor_key_enable <= 2'(e);
      if (e != 2) begin
        run(5, 3'h4);
        chk(rd_q[AERR_BIT], 1'b1);
        clr();
      end
    end
    backdoor_key_enable <= KEYS_ON;
    run(5, 3'h3);
    chk(rd_q[AERR_BIT], 1'b1);
    clr();
    cw[3] = cw[3] ^ 16'h0100;
    for (int t = 0; t < 2; t++) begin
      run(5, 3'h4);
      chk(rd_q[AERR_BIT], 1'b1);
      bus(1, OFF_SECURITY, 32'h0, 4'h0);
      chk(rd_q[7:6], 2'b11);
      clr();
      cw[3] = backdoor_keys[2];
    end
    rst();
    run(5, 3'h4);
    chk(rd_q[AERR_BIT], 1'b0);
    chk(secured, 1'b0);
    rst();
    cur = 4'h0;
    bus(0, OFF_IRQ_MASK, 32'h0000_0001, 4'h1);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      lvl = (i < 8) ? 16'(i >> 1) : {14'h0, seed[2:1]};
      cw[0] = {CMD_MARGIN, seed[0], 7'h00};
      cw[1] = seed[31:16];
      cw[2] = lvl;
      run(3, 3'h2);
      cur = exp_mg(cur, seed[0], lvl);
      chk(read_margin, cur);
      chk(rd_q[AERR_BIT], lvl > MARGIN_MAX);
      bus(1, OFF_MARGIN, 32'h0, 4'h0);
      chk(rd_q[3:0], cur);
      chk(irq, 1'b1);
      clr();
    end
    cw[0] = {CMD_MARGIN, 8'h01};
    cw[2] = 16'h0001;
    run(3, 3'h2);
    chk(rd_q[AERR_BIT], 1'b1);
    // pending error would refuse the next launch
    clr();
    cw[0] = {CMD_MARGIN, 8'h00};
    run(3, 3'h1);
    chk(rd_q[AERR_BIT], 1'b1);
    chk(read_margin, cur);
    results();
  end
endmodule
`default_nettype wire
